/* usdp_pkg.sv */
// constants, field positions and carrier types for the shadow data port
// assumes a 20 MHz bus clock and an APB master in the same domain
// ****************************************************************
// package
// ****************************************************************
package usdp_pkg;
  // address map
  localparam logic [31:0] USDP_DATA_BASE = 32'h5000_1030;
  localparam int USDP_ALIAS_WORDS = 16;
  localparam logic [31:0] USDP_CTRL_ADDR = 32'h5000_1080;
  localparam logic [31:0] USDP_LSTAT_ADDR = 32'h5000_1084;
  localparam logic [31:0] USDP_ISTAT_ADDR = 32'h5000_1088;
  localparam logic [31:0] USDP_IMASK_ADDR = 32'h5000_108c;
  // reset values
  localparam logic [7:0] USDP_DATA_RESET = 8'h00;
  localparam logic [1:0] USDP_CTRL_RESET = 2'h0;
  localparam logic [2:0] USDP_IRQ_RESET = 3'h0;
  // field positions
  localparam int USDP_CTRL_FIFO_BIT = 0;
  localparam int USDP_CTRL_IR_BIT = 1;
  localparam int USDP_LSTAT_DR_BIT = 0;
  localparam int USDP_LSTAT_OE_BIT = 1;
  localparam int USDP_LSTAT_TX_HOLDING_EMPTY_BIT = 5;
  localparam int USDP_LSTAT_TEMT_BIT = 6;
  localparam int USDP_IRQ_W = 3;
  // timing
  localparam int USDP_CLK_HZ = 20_000_000;
  localparam int USDP_BAUD_RATE = 115_200;
  localparam int USDP_BIT_CYCLES = USDP_CLK_HZ / USDP_BAUD_RATE;
  localparam int USDP_IR_PULSE_CYCLES = (USDP_BIT_CYCLES * 3) / 16;
  localparam int USDP_FIFO_DEPTH = 16;
  // carriers
  typedef struct packed {
    logic ir_mode;
    logic fifo_en;
  } usdp_ctl_t;
  typedef struct packed {
    logic tx_holding_empty;
    logic overrun;
    logic rx_data;
  } usdp_evt_t;
  typedef enum logic [1:0] {
    USDP_IDLE = 2'b00,
    USDP_START = 2'b01,
    USDP_DATA = 2'b10,
    USDP_STOP = 2'b11
  } usdp_state_t;
endpackage

/* usdp_shadow_port.sv */
// shadow receive/transmit data port of a serial controller with apb access
// assumes apb master on pclk; serial and infrared inputs are asynchronous pins
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// RULE1: reading the data word gives the byte received on the serial input, or on the infrared input in infrared mode.
// RULE2: sixteen consecutive word addresses all reach the same receive and transmit data path.
// RULE3: software takes the received byte as valid only while the data-ready flag is set.
// RULE4: with fifos off a new character overwrites an unread byte and raises overrun.
// RULE5: with fifos on a data read returns and pops the oldest receive fifo entry.
// RULE6: a character arriving at a full receive fifo is dropped, the fifo kept and overrun raised.
// RULE7: a written byte is sent on the serial output, or on the active-low infrared output in infrared mode.
// RULE8: software writes transmit data only while the transmit-holding-empty flag is set.
// RULE9: with fifos off one write clears the transmit-holding-empty flag.
// RULE10: with fifos off a further write before the flag sets again replaces the pending byte.
// RULE11: with fifos on the transmit fifo takes up to its depth of characters before it is full.
// RULE12: with fifos on a write to a full transmit fifo is dropped and the fifo is unchanged.
// RULE13: data word bits 15 to 8 read as zero and writes to them are ignored.
module usdp_shadow_port #(
  parameter int FIFO_DEPTH = usdp_pkg::USDP_FIFO_DEPTH,
  parameter int BIT_CYCLES = usdp_pkg::USDP_BIT_CYCLES,
  parameter int IR_PULSE_CYCLES = usdp_pkg::USDP_IR_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic ir_rxd,
  output logic txd,
  output logic ir_txd_n,
  output logic irq
);
  import usdp_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(BIT_CYCLES);
  localparam logic [31:0] DATA_END = USDP_DATA_BASE + 32'(USDP_ALIAS_WORDS * 4);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);
  localparam logic [CW-1:0] IR_PULSE = CW'(IR_PULSE_CYCLES);
  localparam logic [AW:0] FIFO_FULL = (AW + 1)'(FIFO_DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(FIFO_DEPTH - 1);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  usdp_ctl_t ctl;
  logic [USDP_IRQ_W-1:0] int_stat;
  logic [USDP_IRQ_W-1:0] int_mask;
  logic overrun_flag;
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire hit_data = (paddr >= USDP_DATA_BASE) && (paddr < DATA_END) && (paddr[1:0] == 2'b00); // RULE2
  wire hit_ctrl = (paddr == USDP_CTRL_ADDR);
  wire hit_lstat = (paddr == USDP_LSTAT_ADDR);
  wire hit_istat = (paddr == USDP_ISTAT_ADDR);
  wire hit_imask = (paddr == USDP_IMASK_ADDR);
  wire hit_any = hit_data | hit_ctrl | hit_lstat | hit_istat | hit_imask;
  wire data_wr = acc & pwrite & hit_data;
  wire data_rd = acc & ~pwrite & hit_data;
  wire ctrl_wr = acc & pwrite & hit_ctrl;
  wire imask_wr = acc & pwrite & hit_imask;
  wire lstat_rd = acc & ~pwrite & hit_lstat;
  wire istat_rd = acc & ~pwrite & hit_istat;
  wire [7:0] wr_byte = pwdata[7:0]; // RULE13
  wire flush = ctrl_wr & (pwdata[USDP_CTRL_FIFO_BIT] != ctl.fifo_en);

  // ****************************************************************
  // receive storage
  // ****************************************************************
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [AW-1:0] rx_wr;
  logic [AW-1:0] rx_rd;
  logic [AW:0] rx_cnt;
  logic [7:0] rx_hold;
  logic rx_hold_valid;
  logic rx_push;
  logic [7:0] rx_shift;
  wire rx_nonempty = (rx_cnt != '0);
  wire rx_pop = data_rd & ctl.fifo_en & rx_nonempty; // RULE5
  wire rx_full = (rx_cnt == FIFO_FULL) & ~rx_pop;
  wire rx_fifo_push = rx_push & ctl.fifo_en & ~rx_full;
  wire rx_overrun = rx_push & (ctl.fifo_en ? rx_full : (rx_hold_valid & ~data_rd)); // RULE4 RULE6
  wire [AW-1:0] rx_wr_nx = (rx_wr == PTR_LAST) ? '0 : rx_wr + 1'b1;
  wire [AW-1:0] rx_rd_nx = (rx_rd == PTR_LAST) ? '0 : rx_rd + 1'b1;
  wire data_ready = ctl.fifo_en ? rx_nonempty : rx_hold_valid; // RULE3
  wire [7:0] rx_byte = ctl.fifo_en ? rx_mem[rx_rd] : rx_hold; // RULE1 RULE5

  always_ff @(posedge pclk) begin
    if (ce && rx_fifo_push) begin
      rx_mem[rx_wr] <= rx_shift;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wr <= '0;
      rx_rd <= '0;
      rx_cnt <= '0;
    end else if (ce) begin
      if (flush) begin
        rx_wr <= '0;
        rx_rd <= '0;
        rx_cnt <= '0;
      end else begin
        rx_wr <= rx_fifo_push ? rx_wr_nx : rx_wr;
        rx_rd <= rx_pop ? rx_rd_nx : rx_rd;
        rx_cnt <= rx_cnt + (AW + 1)'(rx_fifo_push) - (AW + 1)'(rx_pop); // RULE6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hold <= USDP_DATA_RESET;
      rx_hold_valid <= 1'b0;
    end else if (ce) begin
      if (rx_push && !ctl.fifo_en) begin
        rx_hold <= rx_shift; // RULE4
      end
      if (flush) begin
        rx_hold_valid <= 1'b0;
      end else if (rx_push && !ctl.fifo_en) begin
        rx_hold_valid <= 1'b1;
      end else if (data_rd && !ctl.fifo_en) begin
        rx_hold_valid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // receiver
  // ****************************************************************
  logic rxd_s1;
  logic rxd_s2;
  logic ir_s1;
  logic ir_s2;
  usdp_state_t rx_state;
  usdp_state_t next_rx_state;
  logic [CW-1:0] rx_tick;
  logic [2:0] rx_bitn;
  logic rx_mid;
  logic rx_ir_seen;
  wire rx_idle = (rx_state == USDP_IDLE);
  wire rx_bit_end = (rx_tick == BIT_LAST);
  wire rx_line = ctl.ir_mode ? ~ir_s2 : rxd_s2;
  wire rx_bit_val = ctl.ir_mode ? ~rx_ir_seen : rx_mid; // RULE1
  wire rx_start = rx_idle & ~rx_line;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      ir_s1 <= 1'b0;
      ir_s2 <= 1'b0;
    end else if (ce) begin
      rxd_s1 <= rxd;
      rxd_s2 <= rxd_s1;
      ir_s1 <= ir_rxd;
      ir_s2 <= ir_s1;
    end
  end

  always_comb begin
    next_rx_state = rx_state;
    rx_push = 1'b0;
    case (rx_state)
      USDP_IDLE: begin
        if (rx_start) begin
          next_rx_state = USDP_START;
        end
      end
      USDP_START: begin
        if (rx_bit_end) begin
          next_rx_state = rx_bit_val ? USDP_IDLE : USDP_DATA;
        end
      end
      USDP_DATA: begin
        if (rx_bit_end && rx_bitn == 3'd7) begin
          next_rx_state = USDP_STOP;
        end
      end
      USDP_STOP: begin
        if (rx_bit_end) begin
          next_rx_state = USDP_IDLE;
          rx_push = rx_bit_val;
        end
      end
      default: next_rx_state = USDP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= USDP_IDLE;
      rx_tick <= '0;
      rx_mid <= 1'b1;
      rx_ir_seen <= 1'b0;
    end else if (ce) begin
      rx_state <= next_rx_state;
      rx_tick <= (rx_idle || rx_bit_end) ? '0 : rx_tick + 1'b1;
      rx_mid <= (rx_tick == BIT_HALF) ? rx_line : rx_mid;
      rx_ir_seen <= rx_idle ? ir_s2 : (rx_bit_end ? 1'b0 : (rx_ir_seen | ir_s2));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_bitn <= 3'd0;
      rx_shift <= USDP_DATA_RESET;
    end else if (ce && rx_bit_end && rx_state == USDP_DATA) begin
      rx_bitn <= rx_bitn + 3'd1;
      rx_shift <= {rx_bit_val, rx_shift[7:1]};
    end
  end

  // ****************************************************************
  // transmit storage
  // ****************************************************************
  logic [7:0] tx_mem [FIFO_DEPTH];
  logic [AW-1:0] tx_wr;
  logic [AW-1:0] tx_rd;
  logic [AW:0] tx_cnt;
  logic [7:0] tx_hold;
  logic tx_hold_valid;
  logic tx_load;
  wire tx_pop = tx_load & ctl.fifo_en;
  wire tx_full = (tx_cnt == FIFO_FULL); // RULE11
  wire tx_fifo_push = data_wr & ctl.fifo_en & ~tx_full; // RULE12
  wire [AW-1:0] tx_wr_nx = (tx_wr == PTR_LAST) ? '0 : tx_wr + 1'b1;
  wire [AW-1:0] tx_rd_nx = (tx_rd == PTR_LAST) ? '0 : tx_rd + 1'b1;
  wire tx_avail = ctl.fifo_en ? (tx_cnt != '0) : tx_hold_valid;
  wire [7:0] tx_byte = ctl.fifo_en ? tx_mem[tx_rd] : tx_hold;
  wire tx_holding_empty = ctl.fifo_en ? (tx_cnt == '0) : ~tx_hold_valid; // RULE8

  always_ff @(posedge pclk) begin
    if (ce && tx_fifo_push) begin
      tx_mem[tx_wr] <= wr_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wr <= '0;
      tx_rd <= '0;
      tx_cnt <= '0;
    end else if (ce) begin
      if (flush) begin
        tx_wr <= '0;
        tx_rd <= '0;
        tx_cnt <= '0;
      end else begin
        tx_wr <= tx_fifo_push ? tx_wr_nx : tx_wr;
        tx_rd <= tx_pop ? tx_rd_nx : tx_rd;
        tx_cnt <= tx_cnt + (AW + 1)'(tx_fifo_push) - (AW + 1)'(tx_pop); // RULE11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold <= USDP_DATA_RESET;
      tx_hold_valid <= 1'b0;
    end else if (ce) begin
      if (data_wr && !ctl.fifo_en) begin
        tx_hold <= wr_byte; // RULE10
      end
      if (flush) begin
        tx_hold_valid <= 1'b0;
      end else if (data_wr && !ctl.fifo_en) begin
        tx_hold_valid <= 1'b1; // RULE9
      end else if (tx_load && !ctl.fifo_en) begin
        tx_hold_valid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // transmitter
  // ****************************************************************
  usdp_state_t tx_state;
  usdp_state_t next_tx_state;
  logic [CW-1:0] tx_tick;
  logic [2:0] tx_bitn;
  logic [7:0] tx_shift;
  wire tx_idle = (tx_state == USDP_IDLE);
  wire tx_bit_end = (tx_tick == BIT_LAST);
  wire tx_bit = (tx_state == USDP_START) ? 1'b0 :
                (tx_state == USDP_DATA) ? tx_shift[0] : 1'b1;
  wire temt = tx_idle & tx_holding_empty;

  always_comb begin
    next_tx_state = tx_state;
    tx_load = 1'b0;
    case (tx_state)
      USDP_IDLE: begin
        if (tx_avail && !flush) begin
          next_tx_state = USDP_START;
          tx_load = 1'b1;
        end
      end
      USDP_START: begin
        if (tx_bit_end) begin
          next_tx_state = USDP_DATA;
        end
      end
      USDP_DATA: begin
        if (tx_bit_end && tx_bitn == 3'd7) begin
          next_tx_state = USDP_STOP;
        end
      end
      USDP_STOP: begin
        if (tx_bit_end) begin
          next_tx_state = USDP_IDLE;
        end
      end
      default: next_tx_state = USDP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= USDP_IDLE;
      tx_tick <= '0;
      tx_bitn <= 3'd0;
      tx_shift <= USDP_DATA_RESET;
    end else if (ce) begin
      tx_state <= next_tx_state;
      tx_tick <= (tx_idle || tx_bit_end) ? '0 : tx_tick + 1'b1;
      tx_bitn <= (tx_state == USDP_DATA && tx_bit_end) ? tx_bitn + 3'd1 : tx_bitn;
      if (tx_load) begin
        tx_shift <= tx_byte;
      end else if (tx_state == USDP_DATA && tx_bit_end) begin
        tx_shift <= {1'b1, tx_shift[7:1]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 1'b1;
      ir_txd_n <= 1'b1;
    end else if (ce) begin
      txd <= ctl.ir_mode ? 1'b1 : tx_bit; // RULE7
      ir_txd_n <= ~(ctl.ir_mode & ~tx_bit & (tx_tick < IR_PULSE)); // RULE7
    end
  end

  // ****************************************************************
  // events and interrupt
  // ****************************************************************
  logic tx_holding_empty_q;
  usdp_evt_t evt;
  assign evt.rx_data = rx_push & ~rx_overrun;
  assign evt.overrun = rx_overrun;
  assign evt.tx_holding_empty = tx_holding_empty & ~tx_holding_empty_q;
  wire [USDP_IRQ_W-1:0] int_clr = istat_rd ? prdata[USDP_IRQ_W-1:0] : '0;
  wire [USDP_IRQ_W-1:0] next_int_stat = (int_stat & ~int_clr) | evt;
  wire oe_clr = lstat_rd & prdata[USDP_LSTAT_OE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_empty_q <= 1'b1;
      int_stat <= USDP_IRQ_RESET;
      overrun_flag <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      tx_holding_empty_q <= tx_holding_empty;
      int_stat <= next_int_stat;
      overrun_flag <= rx_overrun | (overrun_flag & ~oe_clr); // RULE4 RULE6
      irq <= |(next_int_stat & int_mask);
    end
  end

  // ****************************************************************
  // control registers and apb answer
  // ****************************************************************
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_data) begin
      rd_word = {24'h00_0000, rx_byte}; // RULE1 RULE13
    end else if (hit_ctrl) begin
      rd_word = {30'h0000_0000, ctl};
    end else if (hit_lstat) begin
      rd_word[USDP_LSTAT_DR_BIT] = data_ready;
      rd_word[USDP_LSTAT_OE_BIT] = overrun_flag;
      rd_word[USDP_LSTAT_TX_HOLDING_EMPTY_BIT] = tx_holding_empty;
      rd_word[USDP_LSTAT_TEMT_BIT] = temt;
    end else if (hit_istat) begin
      rd_word = {29'h0000_0000, int_stat};
    end else if (hit_imask) begin
      rd_word = {29'h0000_0000, int_mask};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= USDP_CTRL_RESET;
      int_mask <= USDP_IRQ_RESET;
    end else if (ce) begin
      if (ctrl_wr) begin
        ctl.fifo_en <= pwdata[USDP_CTRL_FIFO_BIT];
        ctl.ir_mode <= pwdata[USDP_CTRL_IR_BIT];
      end
      if (imask_wr) begin
        int_mask <= pwdata[USDP_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~hit_any;
      end else if (acc) begin
        pslverr <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* usdp_checker_assertions.sv */
// checker for the shadow data port: apb answer, data word, serial pins
// bound to usdp_shadow_port; sees its ports only, one clock domain
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module usdp_checker import usdp_pkg::*; #(
  parameter int IR_PULSE_CYCLES = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd,
  input wire logic ir_txd_n,
  input wire logic irq
);
  wire logic data_hit = (paddr - USDP_DATA_BASE) < 32'h40 && paddr[1:0] == 2'h0;
  logic ir_q;
  logic [7:0] low_cnt;
  // mirror of the infrared mode bit and length of the current low pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_q <= 1'b0;
      low_cnt <= 8'h00;
    end else if (ce) begin
      if (psel && penable && pready && pwrite && paddr == USDP_CTRL_ADDR) begin
        ir_q <= pwdata[USDP_CTRL_IR_BIT];
      end
      low_cnt <= ir_txd_n ? 8'h00 : low_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable && ce;
  endsequence
  sequence data_setup_s;
    setup_s ##0 data_hit;
  endsequence
  apb_answer_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  alias_ok_a: assert property (data_setup_s |=> pready && !pslverr)
    else $error("data alias refused");
  upper_zero_a: assert property (pready && !pwrite && data_hit |-> prdata[31:8] == 24'h0)
    else $error("data upper bits not zero");
  err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("error read not zero");
  ir_quiet_a: assert property (ir_q && $past(ir_q, 2) |-> txd)
    else $error("serial output active in infrared mode");
  uart_quiet_a: assert property (!ir_q && !$past(ir_q, 2) |-> ir_txd_n)
    else $error("infrared output active in normal mode");
  ir_pulse_a: assert property ($rose(ir_txd_n) |-> low_cnt == IR_PULSE_CYCLES)
    else $error("infrared pulse width wrong");
  ce_hold_a: assert property (!ce |=> $stable({prdata, pready, pslverr, txd, ir_txd_n, irq}))
    else $error("outputs moved with clock enable low");
endmodule
bind usdp_shadow_port usdp_checker #(.IR_PULSE_CYCLES(IR_PULSE_CYCLES)) usdp_checker_i (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .txd(txd), .ir_txd_n(ir_txd_n), .irq(irq)
);
`default_nettype wire

/* usdp_peer.sv */
// serial peer: sends frames on rxd or ir_rxd, decodes txd, counts infrared pulses
// assumes 8n1 frames of BIT_CYCLES pclk cycles, lsb first
`timescale 1ns/100ps
`default_nettype none
// ****
// peer
// ****
module usdp_peer #(
  parameter int BIT_CYCLES = 16,
  parameter int IR_PULSE_CYCLES = 3
) (
  input wire logic pclk,
  input wire logic txd,
  input wire logic ir_txd_n,
  output logic rxd,
  output logic ir_rxd
);
  logic [7:0] got [$];
  int ir_pulses = 0;
  initial begin
    rxd = 1'b1;
    ir_rxd = 1'b0;
  end
  // one frame; infrared zero bits are short high pulses
  task automatic send(input logic [7:0] b, input logic ir);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int c = 0; c < BIT_CYCLES; c++) begin
        if (ir) begin
          ir_rxd <= !frame[i] && c < IR_PULSE_CYCLES;
        end else begin
          rxd <= frame[i];
        end
        @(posedge pclk);
      end
    end
  endtask
  // receiver samples mid bit, keeps frames with a good stop bit
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge txd);
      repeat (BIT_CYCLES / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge pclk);
        b[i] = txd;
      end
      repeat (BIT_CYCLES) @(posedge pclk);
      if (txd === 1'b1) begin
        got.push_back(b);
      end
    end
  end
  always @(negedge ir_txd_n) begin
    ir_pulses++;
  end
endmodule
`default_nettype wire

/* tb_usdp_shadow_port.sv */
// self-checking bench for the shadow data port
// drives apb and the serial peer on pclk; one clock domain
`timescale 1ns/100ps
`default_nettype none
// ****
// bench
// ****
module tb_usdp_shadow_port;
  import usdp_pkg::*;
  localparam int BC = 16;
  localparam int DEPTH = 4;
  localparam logic [31:0] LS = USDP_LSTAT_ADDR;
  typedef struct packed {logic tx; logic ir; logic [3:0] slot; logic [7:0] b;} usdp_row_t;
  logic [13:0] rows [8] = '{14'h00a5, 14'h0f3c, 14'h175a, 14'h11ff,
                            14'h2396, 14'h2c01, 14'h300f, 14'h39f0};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, rxd, ir_rxd, txd, ir_txd_n, irq, err;
  int miscompares = 0;
  int compares = 0;
  usdp_shadow_port #(.FIFO_DEPTH(DEPTH), .BIT_CYCLES(BC), .IR_PULSE_CYCLES(3))
    usdp_shadow_port_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .ir_rxd(ir_rxd), .txd(txd),
    .ir_txd_n(ir_txd_n), .irq(irq));
  usdp_peer #(.BIT_CYCLES(BC), .IR_PULSE_CYCLES(3)) usdp_peer_i (.pclk(pclk), .txd(txd),
    .ir_txd_n(ir_txd_n), .rxd(rxd), .ir_rxd(ir_rxd));
  initial begin
    forever #25 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic stall();
    miscompares++;
    $display("BAD %0t timeout", $time);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      rdy = pready;
      n++;
    end while (rdy !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (rdy !== 1'b1) stall();
  endtask
  task automatic rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask
  task automatic poll(input int bitn, input logic val);
    int n;
    n = 0;
    do begin
      apb(1'b0, LS, 32'h0);
      n++;
    end while (rd[bitn] !== val && n < 400);
    if (rd[bitn] !== val) stall();
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  initial begin
    usdp_row_t r;
    do_reset();
    rdm(USDP_DATA_BASE, 32'hffff_ffff, {24'h0, USDP_DATA_RESET});
    for (int k = 0; k < 8; k++) begin
      r = usdp_row_t'(rows[k]);
      apb(1'b1, USDP_CTRL_ADDR, {30'h0, r.ir, 1'b0});
      if (r.tx) begin
        usdp_peer_i.ir_pulses = 0;
        poll(USDP_LSTAT_TX_HOLDING_EMPTY_BIT, 1'b1);
        apb(1'b1, USDP_DATA_BASE + {26'h0, r.slot, 2'h0}, {24'h5a5a5a, r.b});
        repeat (12 * BC) @(posedge pclk);
        chk(usdp_peer_i.ir_pulses, r.ir ? 9 - $countones(r.b) : 0);
        chk(usdp_peer_i.got.size(), r.ir ? 0 : 1);
        if (!r.ir) chk(usdp_peer_i.got.pop_front(), r.b);
      end else begin
        usdp_peer_i.send(r.b, r.ir);
        poll(USDP_LSTAT_DR_BIT, 1'b1);
        rdm(USDP_DATA_BASE + {26'h0, r.slot, 2'h0}, 32'hffff_ffff, {24'h0, r.b});
      end
    end
    // overrun without fifos, interrupt masked then raised and cleared
    apb(1'b1, USDP_CTRL_ADDR, 32'h0);
    apb(1'b1, USDP_IMASK_ADDR, 32'h2);
    rdm(USDP_IMASK_ADDR, 32'h7, 32'h2);
    apb(1'b0, USDP_ISTAT_ADDR, 32'h0);
    usdp_peer_i.send(8'h11, 1'b0);
    repeat (8) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    usdp_peer_i.send(8'h22, 1'b0);
    repeat (8) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    ce <= 1'b1;
    rdm(USDP_ISTAT_ADDR, 32'h2, 32'h2);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdm(LS, 32'h3, 32'h3);
    rdm(USDP_DATA_BASE, 32'hffff_ffff, 32'h22);
    // receive fifo filled past its depth, then drained in order
    apb(1'b1, USDP_CTRL_ADDR, 32'h1);
    for (int k = 0; k <= DEPTH; k++) usdp_peer_i.send(8'h40 + 8'(k), 1'b0);
    repeat (8) @(posedge pclk);
    rdm(LS, 32'h3, 32'h3);
    for (int k = 0; k < DEPTH; k++) rdm(USDP_DATA_BASE + 32'(4 * k), 32'hff, 32'h40 + 32'(k));
    rdm(LS, 32'h1, 32'h0);
    // holding register replaced while the first byte is on the line
    apb(1'b1, USDP_CTRL_ADDR, 32'h0);
    apb(1'b1, USDP_DATA_BASE, 32'h81);
    apb(1'b1, USDP_DATA_BASE, 32'h82);
    rdm(LS, 32'h20, 32'h0);
    apb(1'b1, USDP_DATA_BASE, 32'h83);
    repeat (24 * BC) @(posedge pclk);
    chk(usdp_peer_i.got.size(), 2);
    chk(usdp_peer_i.got.pop_front(), 32'h81);
    chk(usdp_peer_i.got.pop_front(), 32'h83);
    // transmit fifo filled until it drops a write
    apb(1'b1, USDP_CTRL_ADDR, 32'h1);
    for (int k = 0; k < DEPTH + 2; k++) apb(1'b1, USDP_DATA_BASE + 32'(4 * k), 32'h90 + 32'(k));
    repeat ((DEPTH + 3) * 11 * BC) @(posedge pclk);
    chk(usdp_peer_i.got.size(), DEPTH + 1);
    for (int k = 0; k <= DEPTH; k++) chk(usdp_peer_i.got.pop_front(), 32'h90 + 32'(k));
    // first word past the aliases is unmapped
    apb(1'b1, 32'h5000_1070, 32'h5);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 32'h5000_1070, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    // reset in mid-run
    do_reset();
    chk({31'h0, txd}, 32'h1);
    rdm(USDP_CTRL_ADDR, 32'h3, 32'h0);
    rdm(USDP_IMASK_ADDR, 32'h7, 32'h0);
    rdm(USDP_DATA_BASE, 32'hffff_ffff, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
